// File: inc/mps_map.svh
// Constants of the microprogram sequencer: offsets, fields, reset values, addresses, timing
// How it works
// - Phase-test hold re-asserts the current phase strobe
// - Two-bit counter flags third consecutive indirect
// - Fetch phases hold both counter bits set
// - Second indirect clears bit 0, third bit 1
// - Third indirect plus interrupt enters interrupt fetch
// - No set strobe maps to address 0000
// - Interrupt fetch strobe maps to address 0004
// - Indirect strobe maps to address 0014
// - Execute decodes instruction bits 10-15 into class
// - Class line plus bits 4-9 give start; arith and I/O use bits 4-8
// - Macro class targets lowest installed module above zero
// - Jump select takes address from microinstruction bits
// - Bits 17,12 pick module; bits 0-7 offset
// - Bus address source drives word bits 0-9
// - Ten-bit microaddress loads from mapper or save
// - Load when load request and strobe low
// - Load on switch, end code, auto-restart
// - Load on jump, call, return, conditional at halt
// - Increment on request with state strobe low
// - Increment needs load, run, no single-cycle conditional
// - Single-cycle conditional inhibits ROM, halts two later
// - Clear while power bad or preset requested
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH

`define MPS_AW            10
`define MPS_IW            16
`define MPS_MW            24

`define MPS_REG_CTRL      4'h0
`define MPS_REG_STATUS    4'h4

`define MPS_CTRL_HOLD     0
`define MPS_CTRL_SINGLE   1
`define MPS_CTRL_MOD_LO   2
`define MPS_CTRL_MOD_HI   4
`define MPS_CTRL_RESET    5'h04

`define MPS_ADDR_FETCH    10'h000
`define MPS_ADDR_INTR     10'h004
`define MPS_ADDR_INDIRECT 10'h00c

`define MPS_BASE_MEM_SHIFT 2'h1
`define MPS_BASE_ALTER    2'h2
`define MPS_BASE_ARITH_IO 2'h3
`define MPS_BASE_MACRO    2'h0

`define MPS_HALT_DELAY    2

`endif

// File: inc/mps_pkg.sv
// Types shared by the microprogram sequencer
package mps_pkg;

   typedef struct packed {
      logic normal_fetch_active;
      logic interrupt_fetch_active;
      logic indirect_active;
      logic execute_active;
   } mps_phase_s;

   typedef struct packed {
      logic set_interrupt_fetch;
      logic set_indirect_phase;
      logic set_execute_phase;
   } mps_set_s;

   typedef struct packed {
      logic micro_jump;
      logic micro_subroutine_call;
      logic micro_subroutine_return;
      logic conditional_micro_jump;
   } mps_func_s;

   typedef enum logic [2:0] {
      MPS_CLS_MEM_SHIFT,
      MPS_CLS_ALTER,
      MPS_CLS_ARITH,
      MPS_CLS_IO,
      MPS_CLS_MACRO
   } mps_class_e;

endpackage

// File: src/mps_sequencer.sv
// Microprogram sequencer: phase hold, indirect counter, mapper and microaddress register
`timescale 1ns/1ps
`include "mps_map.svh"

module mps_sequencer
   import mps_pkg::*;
#(
   parameter int AW = `MPS_AW
) (
   input  wire  logic              clk,
   input  wire  logic              rst_n,
   input  wire  logic [3:0]        reg_addr,
   input  wire  logic [31:0]       reg_wdata,
   input  wire  logic              reg_wr,
   input  wire  logic              reg_rd,
   output logic       [31:0]       reg_rdata,
   input  wire  mps_phase_s        phase,
   input  wire  logic              phase_end,
   input  wire  logic              interrupt_pending,
   input  wire  mps_set_s          proposed_set,
   output mps_set_s                set_out,
   output logic                    third_indirect_flag,
   input  wire  logic [15:0]       instr_word,
   input  wire  logic [23:0]       microinstruction_register,
   input  wire  mps_func_s         func,
   input  wire  logic              address_source_bus,
   input  wire  logic              skip_pending,
   input  wire  logic              halt_entry,
   input  wire  logic              pc_switch,
   input  wire  logic              skip_field_end,
   input  wire  logic              auto_restart,
   input  wire  logic [AW-1:0]     save_address,
   input  wire  logic              microinstruction_load,
   input  wire  logic              run_flag,
   input  wire  logic              state_clock_strobe,
   input  wire  logic              power_good,
   input  wire  logic              preset_request,
   output logic       [AW-1:0]     microaddress,
   output logic                    microaddress_load_n,
   output logic                    microaddress_increment,
   output logic                    micro_jump_select,
   output logic                    rom_inhibit,
   output logic                    halt_request,
   output logic       [9:0]        sbus_data,
   output logic                    sbus_oe
);

   if (AW != `MPS_AW) begin : g_width_check
      $error("mps_sequencer: the mapper forms exactly ten address bits");
   end

   // Reset release through two flops
   logic [1:0]    rst_sync_reg;
   logic          sys_rst_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign sys_rst_n = rst_sync_reg[1];

   // Control and status port
   logic [4:0]    ctrl_reg;
   logic [31:0]   rdata_reg;
   logic [31:0]   rdata_next;
   logic [1:0]    cnt_reg;
   logic          ctrl_hold;
   logic          ctrl_single;
   logic [2:0]    mod_mask;
   wire           hit_ctrl   = (reg_addr == `MPS_REG_CTRL);
   wire           hit_status = (reg_addr == `MPS_REG_STATUS);

   assign ctrl_hold   = ctrl_reg[`MPS_CTRL_HOLD];
   assign ctrl_single = ctrl_reg[`MPS_CTRL_SINGLE];
   assign mod_mask    = ctrl_reg[`MPS_CTRL_MOD_HI:`MPS_CTRL_MOD_LO];
   assign rdata_next  = !reg_rd    ? 32'h0000_0000 :
                        hit_ctrl   ? {27'h000_0000, ctrl_reg} :
                        hit_status ? {19'h0_0000, cnt_reg, third_indirect_flag, microaddress} :
                                     32'h0000_0000;
   assign reg_rdata   = rdata_reg;

   always_ff @(posedge clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         ctrl_reg  <= `MPS_CTRL_RESET;
         rdata_reg <= 32'h0000_0000;
      end else begin
         if (reg_wr && hit_ctrl) begin
            ctrl_reg <= reg_wdata[4:0];
         end
         rdata_reg <= rdata_next;
      end
   end

   // Set-phase strobes toward the phase flip-flops
   wire fetch_active = phase.normal_fetch_active | phase.interrupt_fetch_active;
   wire hold_now     = phase_end & ctrl_hold;
   // Third indirect with an interrupt waiting must not loop in indirect again
   wire redirect     = proposed_set.set_indirect_phase & third_indirect_flag & interrupt_pending;

   assign set_out.set_interrupt_fetch = hold_now ? phase.interrupt_fetch_active :
                                        (proposed_set.set_interrupt_fetch | redirect);
   assign set_out.set_indirect_phase  = hold_now ? phase.indirect_active :
                                        (proposed_set.set_indirect_phase & ~redirect);
   assign set_out.set_execute_phase   = hold_now ? phase.execute_active :
                                        (proposed_set.set_execute_phase & ~redirect);

   // Indirect counter; fetch forces both bits set without waiting for a clock
   logic [1:0]    cnt_eff;
   logic [1:0]    cnt_next;

   assign cnt_eff  = fetch_active ? 2'h3 : cnt_reg;
   assign cnt_next = fetch_active                ? 2'h3 :
                     !set_out.set_indirect_phase ? cnt_reg :
                     cnt_reg[0]                  ? {cnt_reg[1], 1'b0} :
                                                   2'h0;
   assign third_indirect_flag = ~cnt_eff[1];

   always_ff @(posedge clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         cnt_reg <= 2'h3;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // Instruction class decode
   mps_class_e    ir_class;
   wire           is_memref = |instr_word[14:12];

   assign ir_class = is_memref       ? MPS_CLS_MEM_SHIFT :
                     !instr_word[15] ? (instr_word[10] ? MPS_CLS_ALTER : MPS_CLS_MEM_SHIFT) :
                     instr_word[10]  ? MPS_CLS_IO :
                     instr_word[11]  ? MPS_CLS_MACRO : MPS_CLS_ARITH;

   // Macro entries land in the jump table of the lowest installed upper module
   logic [1:0]    macro_module;
   assign macro_module = mod_mask[0] ? 2'h1 : mod_mask[1] ? 2'h2 :
                         mod_mask[2] ? 2'h3 : 2'h1;

   logic [AW-1:0] exec_addr;
   wire  [5:0]    ir_op = instr_word[9:4];

   always_comb begin
      unique case (ir_class)
         MPS_CLS_MEM_SHIFT: exec_addr = {2'h0, `MPS_BASE_MEM_SHIFT, ir_op};
         MPS_CLS_ALTER:     exec_addr = {2'h0, `MPS_BASE_ALTER, ir_op};
         MPS_CLS_ARITH:     exec_addr = {2'h0, `MPS_BASE_ARITH_IO, 1'b0, ir_op[4:0]};
         MPS_CLS_IO:        exec_addr = {2'h0, `MPS_BASE_ARITH_IO, 1'b1, ir_op[4:0]};
         MPS_CLS_MACRO:   exec_addr = {macro_module, `MPS_BASE_MACRO, ir_op};
         default:         exec_addr = `MPS_ADDR_FETCH;
      endcase
   end

   // Phase start address
   logic [AW-1:0] phase_addr;
   wire only_intr = set_out.set_interrupt_fetch & ~set_out.set_indirect_phase
                    & ~set_out.set_execute_phase;
   wire only_ind  = ~set_out.set_interrupt_fetch & set_out.set_indirect_phase
                    & ~set_out.set_execute_phase;
   wire only_exe  = ~set_out.set_interrupt_fetch & ~set_out.set_indirect_phase
                    & set_out.set_execute_phase;

   assign phase_addr = only_intr ? `MPS_ADDR_INTR :
                       only_ind  ? `MPS_ADDR_INDIRECT :
                       only_exe  ? exec_addr :
                                   `MPS_ADDR_FETCH;

   // Jump target; the bus only ever patches the low nibble
   logic [AW-1:0] jump_addr;
   logic [3:0]    jump_low;

   assign sbus_oe   = micro_jump_select & address_source_bus;
   assign sbus_data = sbus_oe ? instr_word[9:0] : 10'h000;
   assign jump_low  = microinstruction_register[3:0] |
                      (sbus_oe ? sbus_data[3:0] : 4'h0);
   assign jump_addr = {microinstruction_register[17], microinstruction_register[12],
                       microinstruction_register[7:4], jump_low};

   // Microaddress control
   wire goto_now  = (func.micro_jump | func.micro_subroutine_call) & ~skip_pending;
   wire cond_now  = func.conditional_micro_jump & (halt_entry | interrupt_pending);
   wire returning = func.micro_subroutine_return;
   wire load_req  = pc_switch | skip_field_end | auto_restart |
                    goto_now | cond_now | returning;
   wire inc_req   = microinstruction_load & run_flag &
                    ~(func.conditional_micro_jump & ctrl_single);
   wire clear_req = ~(power_good & ~preset_request);
   wire load_go   = load_req & ~state_clock_strobe;
   wire inc_go    = inc_req & ~state_clock_strobe;

   logic [AW-1:0] mapper_addr;
   logic [AW-1:0] load_src;
   logic [AW-1:0] microaddress_reg;
   logic [AW-1:0] microaddress_next;

   assign micro_jump_select      = goto_now | cond_now;
   assign mapper_addr            = micro_jump_select ? jump_addr : phase_addr;
   assign load_src               = returning ? save_address : mapper_addr;
   assign microaddress_load_n    = ~load_req;
   assign microaddress_increment = inc_req;
   assign rom_inhibit            = func.conditional_micro_jump & ctrl_single;
   assign microaddress           = microaddress_reg;

   // Clear over load over increment
   assign microaddress_next = clear_req ? {AW{1'b0}} :
                              load_go   ? load_src :
                              inc_go    ? microaddress_reg + {{(AW-1){1'b0}}, 1'b1} :
                                          microaddress_reg;

   always_ff @(posedge clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         microaddress_reg <= {AW{1'b0}};
      end else begin
         microaddress_reg <= microaddress_next;
      end
   end

   // Halt follows the inhibited conditional by two clock periods
   logic [`MPS_HALT_DELAY-1:0] halt_pipe_reg;

   always_ff @(posedge clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         halt_pipe_reg <= '0;
      end else begin
         halt_pipe_reg <= {halt_pipe_reg[`MPS_HALT_DELAY-2:0], rom_inhibit};
      end
   end
   assign halt_request = halt_pipe_reg[`MPS_HALT_DELAY-1];

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!sys_rst_n);

   phase_hold_a: assert property (
      hold_now && phase.indirect_active && !phase.interrupt_fetch_active
      && !phase.execute_active |-> set_out == 3'b010)
      else $error("hold did not repeat the indirect phase");

   third_count_a: assert property (
      !fetch_active && cnt_reg == 2'h2 && set_out.set_indirect_phase
      ##1 !fetch_active |-> third_indirect_flag && cnt_reg == 2'h0)
      else $error("third indirect did not raise the flag");

   second_count_a: assert property (
      !fetch_active && cnt_reg == 2'h3 && set_out.set_indirect_phase
      |=> cnt_reg == 2'h2)
      else $error("second indirect did not clear bit zero");

   fetch_hold_a: assert property (
      fetch_active |-> !third_indirect_flag ##1 cnt_reg == 2'h3)
      else $error("fetch did not hold the counter set");

   intr_redirect_a: assert property (
      !hold_now && third_indirect_flag && interrupt_pending
      && proposed_set.set_indirect_phase
      |-> set_out.set_interrupt_fetch && !set_out.set_indirect_phase)
      else $error("third indirect with interrupt stayed indirect");

   fetch_map_a: assert property (
      load_go && !clear_req && !returning && !micro_jump_select && set_out == 3'b000
      |=> microaddress == `MPS_ADDR_FETCH)
      else $error("normal fetch start address wrong");

   intr_map_a: assert property (
      load_go && !clear_req && !returning && !micro_jump_select && only_intr
      |=> microaddress == `MPS_ADDR_INTR)
      else $error("interrupt fetch start address wrong");

   indirect_map_a: assert property (
      load_go && !clear_req && !returning && !micro_jump_select && only_ind
      |=> microaddress == `MPS_ADDR_INDIRECT)
      else $error("indirect start address wrong");

   jump_module_a: assert property (
      load_go && !clear_req && !returning && micro_jump_select
      |=> microaddress[9:8] == {$past(microinstruction_register[17]),
                                $past(microinstruction_register[12])})
      else $error("jump module bits wrong");

   return_load_a: assert property (
      returning && load_go && !clear_req |=> microaddress == $past(save_address))
      else $error("return did not load the saved address");

   step_inc_a: assert property (
      inc_go && !load_go && !clear_req
      |=> microaddress == $past(microaddress) + 10'h001)
      else $error("increment did not step the address");

   clear_first_a: assert property (
      clear_req |=> microaddress == `MPS_ADDR_FETCH)
      else $error("clear did not win");

   halt_delay_a: assert property (
      rom_inhibit && !$past(rom_inhibit) |-> !halt_request ##2 halt_request)
      else $error("halt not two periods after inhibit");

   single_hold_a: assert property (
      rom_inhibit && !load_req && !clear_req |=> microaddress == $past(microaddress))
      else $error("single-cycle conditional moved the address");

   load_cause_a: assert property (
      pc_switch || skip_field_end || auto_restart |-> !microaddress_load_n)
      else $error("switch, end code or restart did not request a load");

   code_load_a: assert property (
      (func.micro_jump || func.micro_subroutine_call) && !skip_pending
      || func.micro_subroutine_return |-> !microaddress_load_n)
      else $error("jump, call or return did not request a load");

   strobe_block_a: assert property (
      state_clock_strobe && !clear_req |=> microaddress == $past(microaddress))
      else $error("address moved while the state strobe was high");

   bus_drive_a: assert property (
      sbus_oe |-> micro_jump_select && sbus_data == instr_word[9:0])
      else $error("bus address source drove the wrong word");

   jump_offset_a: assert property (
      load_go && !clear_req && !returning && micro_jump_select && !sbus_oe
      |=> microaddress[7:0] == $past(microinstruction_register[7:0]))
      else $error("jump offset not taken from the microinstruction");

   bus_patch_a: assert property (
      load_go && !clear_req && !returning && sbus_oe
      |=> microaddress[3:0] == ($past(microinstruction_register[3:0])
                                | $past(instr_word[3:0])))
      else $error("bus nibble did not patch the jump address");

   inc_gate_a: assert property (
      microaddress_increment |-> microinstruction_load && run_flag && !rom_inhibit)
      else $error("increment requested without its conditions");

   macro_target_a: assert property (
      load_go && !clear_req && !returning && !micro_jump_select && only_exe
      && ir_class == MPS_CLS_MACRO
      |=> microaddress[9:8] != 2'h0 && microaddress[7:6] == 2'h0)
      else $error("macro entry missed the upper module jump table");

   memref_class_a: assert property (
      load_go && !clear_req && !returning && !micro_jump_select && only_exe
      && instr_word[14:12] != 3'h0 |=> microaddress[9:6] == 4'h1)
      else $error("memory reference start outside its block");

   cover_third_c:   cover property (third_indirect_flag && interrupt_pending);
   cover_macro_c:   cover property (load_go && only_exe && ir_class == MPS_CLS_MACRO);
   cover_jump_c:    cover property (load_go && micro_jump_select && sbus_oe);
   cover_halt_c:    cover property (halt_request);
   cover_return_c:  cover property (load_go && returning);

endmodule

// File: sim/mps_rom_model.sv
// Behavioural microcode store at the far side of the sequencer
`timescale 1ns/1ps
module mps_rom_model (
   input  wire logic [9:0]  microaddress,
   input  wire logic        rom_inhibit,
   output logic      [23:0] rom_word
);
   // Every word read while rom_inhibit is low is a jump pattern built from its own address, so each target is predictable
   assign rom_word = rom_inhibit ? 24'hff_ffff :
      {6'h00, microaddress[0], 4'h0, microaddress[1], 4'h0, microaddress[7:0] ^ 8'h35};
endmodule

// File: sim/microprogram_sequencer_tb_top.sv
// Self-checking bench for the microprogram sequencer
`timescale 1ns/1ps
module microprogram_sequencer_tb_top;
   import mps_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   mps_phase_s  phase = '0;
   logic        phase_end = 1'b0;
   logic        interrupt_pending = 1'b0;
   mps_set_s    proposed_set = '0;
   mps_set_s    set_out;
   logic        third_indirect_flag;
   logic [15:0] instr_word = '0;
   logic [23:0] microinstruction_register;
   mps_func_s   func = '0;
   logic        address_source_bus = 1'b0;
   logic        skip_pending = 1'b0;
   logic        halt_entry = 1'b0;
   logic        pc_switch = 1'b0;
   logic        skip_field_end = 1'b0;
   logic        auto_restart = 1'b0;
   logic [9:0]  save_address = 10'h2a5;
   logic        microinstruction_load = 1'b0;
   logic        run_flag = 1'b0;
   logic        state_clock_strobe = 1'b1;
   logic        power_good = 1'b1;
   logic        preset_request = 1'b0;
   logic [9:0]  microaddress;
   logic        microaddress_load_n;
   logic        microaddress_increment;
   logic        micro_jump_select;
   logic        rom_inhibit;
   logic        halt_request;
   logic [9:0]  sbus_data;
   logic        sbus_oe;
   int          num_errors = 0;
   int          total_checks = 0;
   logic [15:0] iw_tab [7] = '{16'h12a0, 16'h0150, 16'h0550, 16'h8150, 16'h8550, 16'h8950,
                               16'h8950};
   logic [9:0]  ex_tab [7] = '{10'h06a, 10'h055, 10'h095, 10'h0d5, 10'h0f5, 10'h115, 10'h215};
   logic [31:0] cnt_tab [3] = '{32'h0000_1800, 32'h0000_1000, 32'h0000_0400};

   always #25 clk = ~clk;

   mps_sequencer uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .phase, .phase_end, .interrupt_pending, .proposed_set, .set_out, .third_indirect_flag,
      .instr_word, .microinstruction_register, .func, .address_source_bus, .skip_pending,
      .halt_entry, .pc_switch, .skip_field_end, .auto_restart, .save_address,
      .microinstruction_load, .run_flag, .state_clock_strobe, .power_good, .preset_request,
      .microaddress, .microaddress_load_n, .microaddress_increment, .micro_jump_select,
      .rom_inhibit, .halt_request, .sbus_data, .sbus_oe);

   mps_rom_model rom (.microaddress(microaddress), .rom_inhibit(rom_inhibit),
      .rom_word(microinstruction_register));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      chk("reg_rdata", reg_rdata, exp);
   endtask

   // The operation edge returns every request line to idle so no later edge repeats it
   task automatic commit(input logic [9:0] exp);
      @(posedge clk);
      state_clock_strobe    <= 1'b1;
      {pc_switch, skip_field_end, auto_restart} <= 3'b000;
      func                  <= '0;
      halt_entry            <= 1'b0;
      address_source_bus    <= 1'b0;
      microinstruction_load <= 1'b0;
      skip_pending          <= 1'b0;
      preset_request        <= 1'b0;
      power_good            <= 1'b1;
      @(negedge clk);
      chk("microaddress", 32'(microaddress), 32'(exp));
   endtask

   task automatic op(input logic [2:0] src, input logic [2:0] s, input logic [3:0] f,
                     input logic bus, input logic [15:0] iw, input logic st,
                     input logic [9:0] exp);
      @(posedge clk);
      {pc_switch, skip_field_end, auto_restart} <= src;
      proposed_set       <= s;
      func               <= f;
      halt_entry         <= f[0];
      address_source_bus <= bus;
      instr_word         <= iw;
      state_clock_strobe <= st;
      @(negedge clk);
      chk("microaddress_load_n", 32'(microaddress_load_n), 32'h0);
      chk("micro_jump_select", 32'(micro_jump_select), 32'(f[3] | f[2] | f[0]));
      chk("sbus_oe", 32'(sbus_oe), 32'(bus));
      if (bus) begin
         chk("sbus_data", 32'(sbus_data), 32'(iw[9:0]));
      end
      commit(exp);
   endtask

   task automatic inc(input logic rf, input logic st, input logic [9:0] exp);
      @(posedge clk);
      run_flag              <= rf;
      microinstruction_load <= 1'b1;
      state_clock_strobe    <= st;
      @(negedge clk);
      chk("microaddress_increment", 32'(microaddress_increment), 32'(rf));
      commit(exp);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      rdchk(4'h0, 32'h0000_0004);
      chk("microaddress", 32'(microaddress), 32'h0);
      wr(4'h8, 32'h0000_0003);
      wr(4'h4, 32'h0000_07ff);
      rdchk(4'h8, 32'h0000_0000);
      rdchk(4'h4, 32'h0000_1800);
      op(3'b100, 3'b010, 4'h0, 1'b0, 16'h0000, 1'b0, 10'h00c);
      op(3'b001, 3'b100, 4'h0, 1'b0, 16'h0000, 1'b0, 10'h004);
      op(3'b010, 3'b000, 4'h0, 1'b0, 16'h0000, 1'b0, 10'h000);
      op(3'b010, 3'b010, 4'h0, 1'b0, 16'h0000, 1'b1, 10'h000);
      for (int i = 0; i < 7; i++) begin
         if (i == 6) begin
            wr(4'h0, 32'h0000_0018);
         end
         op(3'b010, 3'b001, 4'h0, 1'b0, iw_tab[i], 1'b0, ex_tab[i]);
      end
      op(3'b010, 3'b010, 4'h0, 1'b0, 16'h0000, 1'b0, 10'h00c);
      op(3'b000, 3'b000, 4'h8, 1'b0, 16'h0000, 1'b0, 10'h039);
      op(3'b000, 3'b000, 4'h8, 1'b1, 16'h0006, 1'b0, 10'h20e);
      op(3'b000, 3'b000, 4'h8, 1'b0, 16'h0000, 1'b0, 10'h13b);
      @(posedge clk);
      skip_pending       <= 1'b1;
      func               <= 4'h8;
      state_clock_strobe <= 1'b0;
      @(negedge clk);
      chk("microaddress_load_n", 32'(microaddress_load_n), 32'h1);
      commit(10'h13b);
      op(3'b000, 3'b000, 4'h1, 1'b0, 16'h0000, 1'b0, 10'h30e);
      op(3'b000, 3'b000, 4'h4, 1'b0, 16'h0000, 1'b0, 10'h13b);
      op(3'b000, 3'b000, 4'h2, 1'b0, 16'h0000, 1'b0, 10'h2a5);
      inc(1'b1, 1'b0, 10'h2a6);
      inc(1'b0, 1'b0, 10'h2a6);
      inc(1'b1, 1'b1, 10'h2a6);
      @(posedge clk);
      preset_request <= 1'b1;
      op(3'b010, 3'b010, 4'h0, 1'b0, 16'h0000, 1'b0, 10'h000);
      inc(1'b1, 1'b0, 10'h001);
      @(posedge clk);
      power_good <= 1'b0;
      inc(1'b1, 1'b1, 10'h000);
      wr(4'h0, 32'h0000_001a);
      @(posedge clk);
      func                  <= 4'h1;
      microinstruction_load <= 1'b1;
      state_clock_strobe    <= 1'b0;
      @(negedge clk);
      chk("rom_inhibit", 32'(rom_inhibit), 32'h1);
      chk("microaddress_increment", 32'(microaddress_increment), 32'h0);
      chk("rom_word", 32'(microinstruction_register), 32'h00ff_ffff);
      commit(10'h000);
      chk("halt_request", 32'(halt_request), 32'h0);
      // Halt stands for the one period two after the inhibited conditional
      @(negedge clk);
      chk("halt_request", 32'(halt_request), 32'h1);
      @(negedge clk);
      chk("halt_request", 32'(halt_request), 32'h0);
      wr(4'h0, 32'h0000_0019);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         phase        <= mps_phase_s'(4'b1000 >> i);
         phase_end    <= 1'b1;
         proposed_set <= 3'b110;
         @(negedge clk);
         chk("set_out", 32'(set_out), 32'((4'b1000 >> i) & 4'b0111));
      end
      wr(4'h0, 32'h0000_0018);
      @(negedge clk);
      chk("set_out", 32'(set_out), 32'h6);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         phase        <= (i == 0) ? 4'b1000 : 4'b0010;
         phase_end    <= 1'b0;
         proposed_set <= 3'b010;
         @(posedge clk);
         proposed_set <= 3'b000;
         rdchk(4'h4, cnt_tab[i]);
      end
      chk("third_indirect_flag", 32'(third_indirect_flag), 32'h1);
      @(posedge clk);
      interrupt_pending <= 1'b1;
      proposed_set      <= 3'b010;
      @(negedge clk);
      chk("set_out", 32'(set_out), 32'h4);
      @(posedge clk);
      phase <= 4'b1000;
      @(negedge clk);
      chk("third_indirect_flag", 32'(third_indirect_flag), 32'h0);
      report_and_stop();
   end

   // The sequence needs about a hundred cycles; this limit is some twenty times that
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
endmodule
